/* rtl/pspd_top.sv */
// Port A/B datapath of a 36-bit FIFO: port-B swap and sizing, parity gen/check
//
// Operation
// - Swap selects: 00 none, 01 byte swap, 10 word swap, 11 byte-word swap.
// - Port-B read: swap whole word then size; write: size then swap.
// - Swap and sizing are independent; swap exists on port B only.
// - Swaps move whole bytes; selects sampled each port-B clock, may change.
// - Size selects give long, word or byte; endian select picks the lane.
// - Odd or even parity can go in each byte's top bit on either port.
// - Odd parity: nine bits hold odd ones; even: even ones.
// - Read parity generation needs select low, generate high, enable high.
// - Writes to FIFO or mailbox store every input bit of the lanes in use unchanged.
// - Parity computed from each byte's lower eight bits, chosen polarity.
// - Generation on: generated bit loaded; off: stored top bit passes.
// - Mailbox read parity: read, mailbox select, generate; contents untouched.
// - Port-B trees shared by FIFO gen/check and mailbox; port A likewise.
// - Each port has four 9-bit trees, ninth bit is the parity position.
// - Active-low error flag goes low when any input byte fails.
// - Odd select not asserted means even parity everywhere.
// - With sizing, only lanes in use are checked; others suppressed.
// - Check is passive on inputs; it never blocks or alters the write.
`timescale 1ns/1ps
module pspd_top
    import pspd_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Port A pins
    input  wire logic [35:0] a_data_i,
    output logic      [35:0] a_data_o,
    output logic             a_data_oe_o,
    input  wire logic        port_a_select_n_i,
    input  wire logic        port_a_enable_i,
    input  wire logic        a_write_i,
    input  wire logic        a_mail_i,
    input  wire logic        parity_gen_port_a_i,
    output logic             parity_error_port_a_n_o,
    // Port B pins
    input  wire logic [35:0] b_data_i,
    output logic      [35:0] b_data_o,
    output logic             b_data_oe_o,
    input  wire logic        port_b_select_n_i,
    input  wire logic        port_b_enable_i,
    input  wire logic        b_write_i,
    input  wire logic        b_mail_i,
    input  wire logic        parity_gen_port_b_i,
    input  wire logic        swap_select_lo_i,
    input  wire logic        swap_select_hi_i,
    input  wire logic        size_select_lo_i,
    input  wire logic        size_select_hi_i,
    input  wire logic        endian_select_n_i,
    output logic             parity_error_port_b_n_o,
    // Memory core, A to B direction
    output logic      [35:0] a_core_wdata_o,
    output logic             a_core_we_o,
    input  wire logic [35:0] b_core_rdata_i,
    output logic             b_core_rd_o,
    // Memory core, B to A direction
    output logic      [35:0] b_core_wdata_o,
    output logic             b_core_we_o,
    input  wire logic [35:0] a_core_rdata_i,
    output logic             a_core_rd_o
);

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    logic [PSPD_PIN_W-1:0] pin_raw;
    logic [PSPD_PIN_W-1:0] pin_s1_q;
    logic [PSPD_PIN_W-1:0] pin_s2_q;

    assign pin_raw = {a_data_i, port_a_select_n_i, port_a_enable_i, a_write_i, a_mail_i,
                      parity_gen_port_a_i, b_data_i, port_b_select_n_i, port_b_enable_i,
                      b_write_i, b_mail_i, parity_gen_port_b_i, swap_select_lo_i,
                      swap_select_hi_i, size_select_lo_i, size_select_hi_i,
                      endian_select_n_i};

    // Two stages; only the second stage feeds logic
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    logic [35:0] a_din;
    logic [35:0] b_din;
    logic        a_cs_n, a_en, a_wsel, a_mail, a_pg;
    logic        b_cs_n, b_en, b_wsel, b_mail, b_pg, b_big;
    pspd_swap_t  b_sw;
    pspd_size_t  b_szsel;

    assign {a_din, a_cs_n, a_en, a_wsel, a_mail, a_pg} = pin_s2_q[86:46];
    assign {b_din, b_cs_n, b_en, b_wsel, b_mail, b_pg} = pin_s2_q[45:5];
    assign b_sw    = pspd_swap_t'(pin_s2_q[4:3]);
    assign b_szsel = pspd_size_t'(pin_s2_q[2:1]);
    assign b_big   = ~pin_s2_q[0];                            // Low selects big endian

    // ========================================================================
    // APB registers
    // ========================================================================
    logic        odd_q;
    logic [1:0]  err_sticky_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        a_perr_n_q, b_perr_n_q;
    logic [1:0]  b_idx_q;
    logic [31:0] rd_mux;
    logic        addr_hit;
    logic        apb_setup, apb_wr;

    assign apb_setup = psel_i & ~penable_i & ~pready_q;
    assign apb_wr    = psel_i & penable_i & pready_q & pwrite_i & addr_hit;

    // Address decode; unmapped addresses answer with an error
    always_comb
    begin
        rd_mux   = PSPD_RDATA_RST;
        addr_hit = 1'b1;
        if (paddr_i == PSPD_OFF_CTRL)
            rd_mux[PSPD_CTRL_ODD_BIT] = odd_q;
        else if (paddr_i == PSPD_OFF_STATUS)
        begin
            rd_mux[PSPD_STAT_ERRB_BIT:PSPD_STAT_ERRA_BIT] = err_sticky_q;
            rd_mux[PSPD_STAT_IDX_LSB +: 2]                = b_idx_q;
        end
        else
            addr_hit = 1'b0;
    end

    // No wait state: ready registered at the setup edge
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= PSPD_RDATA_RST;
        end
        else
        begin
            pready_q  <= apb_setup;
            pslverr_q <= apb_setup & ~addr_hit;
            prdata_q  <= apb_setup ? rd_mux : prdata_q;
        end
    end

    // Control and sticky errors; a new error wins over a clearing write
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            odd_q        <= PSPD_CTRL_ODD_RST;
            err_sticky_q <= '0;
        end
        else
        begin
            if (apb_wr && paddr_i == PSPD_OFF_CTRL)
                odd_q <= pwdata_i[PSPD_CTRL_ODD_BIT];
            err_sticky_q <= {~b_perr_n_q, ~a_perr_n_q}
                          | (err_sticky_q & ~({2{apb_wr && paddr_i == PSPD_OFF_STATUS}}
                                              & pwdata_i[1:0]));
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;

    // ========================================================================
    // Port A
    // ========================================================================
    logic        a_wr, a_rd;
    logic [35:0] a_src, a_tree_in;
    logic [3:0]  a_gen, a_err;
    logic [35:0] a_dout_q, a_core_wdata_q, mbox_ab_q, mbox_ba_q;
    logic        a_oe_q, a_core_we_q, a_core_rd_q;

    assign a_wr      = ~a_cs_n & a_en & a_wsel;
    assign a_rd      = ~a_cs_n & a_en & ~a_wsel;
    assign a_src     = a_mail ? mbox_ba_q : a_core_rdata_i;
    assign a_tree_in = a_wr ? a_din : a_src;

    pspd_parity_tree u_tree_a (
        .word_i (a_tree_in),
        .odd_i  (odd_q),
        .gen_o  (a_gen),
        .err_o  (a_err)
    );

    // Writes store raw pins; checking only reports
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            a_dout_q       <= '0;
            a_oe_q         <= 1'b0;
            a_core_wdata_q <= '0;
            a_core_we_q    <= 1'b0;
            a_core_rd_q    <= 1'b0;
            mbox_ab_q      <= '0;
            a_perr_n_q     <= 1'b1;
        end
        else
        begin
            a_dout_q       <= a_rd ? pspd_insert(a_src, a_gen, a_pg) : a_dout_q;
            a_oe_q         <= ~a_cs_n & ~a_wsel;
            a_core_wdata_q <= (a_wr & ~a_mail) ? a_din : a_core_wdata_q;
            a_core_we_q    <= a_wr & ~a_mail;
            a_core_rd_q    <= a_rd & ~a_mail;
            mbox_ab_q      <= (a_wr & a_mail) ? a_din : mbox_ab_q;
            a_perr_n_q     <= ~(a_wr & (|a_err));
        end
    end

    assign a_data_o                = a_dout_q;
    assign a_data_oe_o             = a_oe_q;
    assign a_core_wdata_o          = a_core_wdata_q;
    assign a_core_we_o             = a_core_we_q;
    assign a_core_rd_o             = a_core_rd_q;
    assign parity_error_port_a_n_o = a_perr_n_q;

    // ========================================================================
    // Port B: swap, sizing, parity
    // ========================================================================
    logic        b_wr, b_rd, b_fifo_op, b_last_piece;
    pspd_size_t  b_sz;
    logic [1:0]  b_last, b_ord;
    logic [3:0]  b_mask, b_gen, b_err;
    logic [35:0] b_rd_word, b_gen_word, b_tree_in, b_rd_next, b_asm_next;
    logic [35:0] b_dout_q, b_asm_q, b_core_wdata_q;
    logic        b_oe_q, b_core_we_q, b_core_rd_q;

    assign b_wr  = ~b_cs_n & b_en & b_wsel;
    assign b_rd  = ~b_cs_n & b_en & ~b_wsel;
    // Mailbox traffic and the spare code run as long words
    assign b_sz  = (b_mail || b_szsel == PSPD_SIZE_RSVD) ? PSPD_SIZE_LONG : b_szsel;
    assign b_last = (b_sz == PSPD_SIZE_BYTE) ? 2'd3 : (b_sz == PSPD_SIZE_WORD) ? 2'd1 : 2'd0;
    assign b_ord  = b_big ? (b_last - b_idx_q) : b_idx_q;        // Big endian: high first
    assign b_fifo_op    = (b_wr | b_rd) & ~b_mail;
    assign b_last_piece = (b_idx_q == b_last);

    // Read swaps the whole word before any sizing
    assign b_rd_word  = b_mail ? mbox_ab_q : pspd_swap(b_core_rdata_i, b_sw);
    assign b_tree_in  = b_wr ? b_din : b_rd_word;
    assign b_gen_word = pspd_insert(b_rd_word, b_gen, b_pg);

    // Only lanes carrying data are checked
    assign b_mask = (b_sz == PSPD_SIZE_LONG) ? 4'hf
                  : (b_sz == PSPD_SIZE_WORD) ? (b_big ? 4'hc : 4'h3)
                  : (b_big ? 4'h8 : 4'h1);

    pspd_parity_tree u_tree_b (
        .word_i (b_tree_in),
        .odd_i  (odd_q),
        .gen_o  (b_gen),
        .err_o  (b_err)
    );

    // Narrow read: unused lanes keep their last values
    always_comb
    begin
        b_rd_next  = b_dout_q;
        b_asm_next = b_asm_q;
        case (b_sz)
            PSPD_SIZE_WORD:
            begin
                if (b_big)
                    b_rd_next[35:18] = b_gen_word[18*b_ord[0] +: 18];
                else
                    b_rd_next[17:0]  = b_gen_word[18*b_ord[0] +: 18];
                b_asm_next[18*b_ord[0] +: 18] = b_big ? b_din[35:18] : b_din[17:0];
            end
            PSPD_SIZE_BYTE:
            begin
                if (b_big)
                    b_rd_next[35:27] = b_gen_word[9*b_ord +: 9];
                else
                    b_rd_next[8:0]   = b_gen_word[9*b_ord +: 9];
                b_asm_next[9*b_ord +: 9] = b_big ? b_din[35:27] : b_din[8:0];
            end
            default:
            begin
                b_rd_next  = b_gen_word;
                b_asm_next = b_din;
            end
        endcase
    end

    // Write assembles pieces first, swaps on the last one
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            b_dout_q       <= '0;
            b_oe_q         <= 1'b0;
            b_asm_q        <= '0;
            b_idx_q        <= '0;
            b_core_wdata_q <= '0;
            b_core_we_q    <= 1'b0;
            b_core_rd_q    <= 1'b0;
            mbox_ba_q      <= '0;
            b_perr_n_q     <= 1'b1;
        end
        else
        begin
            b_dout_q    <= b_rd ? b_rd_next : b_dout_q;
            b_oe_q      <= ~b_cs_n & ~b_wsel;
            b_asm_q     <= (b_wr & ~b_mail) ? b_asm_next : b_asm_q;
            b_idx_q     <= (b_fifo_op & ~b_last_piece) ? b_idx_q + 2'd1
                         : b_fifo_op ? 2'd0 : b_idx_q;
            b_core_wdata_q <= (b_wr & ~b_mail & b_last_piece)
                            ? pspd_swap(b_asm_next, b_sw) : b_core_wdata_q;
            b_core_we_q <= b_wr & ~b_mail & b_last_piece;
            b_core_rd_q <= b_rd & ~b_mail & b_last_piece;
            mbox_ba_q   <= (b_wr & b_mail) ? b_din : mbox_ba_q;
            b_perr_n_q  <= ~(b_wr & (|(b_err & b_mask)));
        end
    end

    assign b_data_o                = b_dout_q;
    assign b_data_oe_o             = b_oe_q;
    assign b_core_wdata_o          = b_core_wdata_q;
    assign b_core_we_o             = b_core_we_q;
    assign b_core_rd_o             = b_core_rd_q;
    assign parity_error_port_b_n_o = b_perr_n_q;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_a_gen_read;
        a_rd && a_pg;
    endsequence

    sequence s_b_long_byteswap;
        b_rd && !b_mail && b_sz == PSPD_SIZE_LONG && b_sw == PSPD_SWAP_BYTE && !b_pg;
    endsequence

    property p_a_err_flag;
        a_wr && (|a_err) |=> !parity_error_port_a_n_o
            ##1 (parity_error_port_a_n_o || $past(a_wr && (|a_err)));
    endproperty
    a_a_err_flag: assert property (p_a_err_flag)
        else $error("port A parity error flag not driven low");

    property p_b_unused_lane;
        b_wr && (b_err & b_mask) == 4'h0 |=> parity_error_port_b_n_o;
    endproperty
    a_b_unused_lane: assert property (p_b_unused_lane)
        else $error("port B flag raised by an unused lane");

    property p_a_gen_parity;
        s_a_gen_read |=> (^a_data_o[8:0]) == $past(odd_q) && (^a_data_o[17:9]) == $past(odd_q)
                      && (^a_data_o[26:18]) == $past(odd_q) && (^a_data_o[35:27]) == $past(odd_q);
    endproperty
    a_a_gen_parity: assert property (p_a_gen_parity)
        else $error("port A generated parity has wrong polarity");

    property p_a_pass_top;
        a_rd && !a_pg |=> a_data_o == $past(a_src);
    endproperty
    a_a_pass_top: assert property (p_a_pass_top)
        else $error("port A read altered data without parity generate");

    property p_a_mail_store;
        a_wr && a_mail |=> mbox_ab_q == $past(a_din) && !a_core_we_o;
    endproperty
    a_a_mail_store: assert property (p_a_mail_store)
        else $error("mailbox write did not store raw input");

    property p_mail_read_keep;
        s_a_gen_read ##0 a_mail && !(b_wr && b_mail) |=> $stable(mbox_ba_q);
    endproperty
    a_mail_read_keep: assert property (p_mail_read_keep)
        else $error("mailbox changed by a parity generating read");

    property p_b_byteswap;
        s_b_long_byteswap |=> b_data_o == {$past(b_core_rdata_i[8:0]),
            $past(b_core_rdata_i[17:9]), $past(b_core_rdata_i[26:18]),
            $past(b_core_rdata_i[35:27])};
    endproperty
    a_b_byteswap: assert property (p_b_byteswap)
        else $error("port B byte swap order wrong");

    property p_b_write_commit;
        b_wr && !b_mail |=> b_core_we_o == $past(b_last_piece);
    endproperty
    a_b_write_commit: assert property (p_b_write_commit)
        else $error("port B core write not on last piece");

endmodule

/* rtl/pspd_pkg.sv */
// Package: constants, select encodings and word helpers of the port swap/parity datapath
package pspd_pkg;

    // ========================================================================
    // Word geometry
    // ========================================================================
    localparam int unsigned PSPD_WORD_W  = 36;
    localparam int unsigned PSPD_BYTES   = 4;
    localparam int unsigned PSPD_BYTE_W  = 9;
    localparam int unsigned PSPD_PIN_W   = 87;      // Synchronised pin bundle width
    localparam int unsigned PSPD_SYNC_STAGES = 2;

    // ========================================================================
    // APB register map (byte addresses) and fields
    // ========================================================================
    localparam logic [7:0]  PSPD_OFF_CTRL   = 8'h00;
    localparam logic [7:0]  PSPD_OFF_STATUS = 8'h04;
    localparam int unsigned PSPD_CTRL_ODD_BIT   = 0;
    localparam int unsigned PSPD_STAT_ERRA_BIT  = 0;
    localparam int unsigned PSPD_STAT_ERRB_BIT  = 1;
    localparam int unsigned PSPD_STAT_IDX_LSB   = 4;
    localparam logic        PSPD_CTRL_ODD_RST   = 1'b0;   // Even parity after reset
    localparam logic [31:0] PSPD_RDATA_RST      = 32'h0000_0000;

    // ========================================================================
    // Select encodings
    // ========================================================================
    // Swap select, coded {swap_select_lo, swap_select_hi}
    typedef enum logic [1:0] {
        PSPD_SWAP_NONE     = 2'b00,
        PSPD_SWAP_BYTE     = 2'b01,
        PSPD_SWAP_WORD     = 2'b10,
        PSPD_SWAP_BYTEWORD = 2'b11
    } pspd_swap_t;

    // Size select, coded {size_select_lo, size_select_hi}
    typedef enum logic [1:0] {
        PSPD_SIZE_LONG = 2'b00,
        PSPD_SIZE_WORD = 2'b01,
        PSPD_SIZE_BYTE = 2'b10,
        PSPD_SIZE_RSVD = 2'b11
    } pspd_size_t;

    // ========================================================================
    // Helpers
    // ========================================================================
    // Whole bytes move; bit order inside a byte stays put
    function automatic logic [35:0] pspd_swap(input logic [35:0] w, input pspd_swap_t m);
        logic [35:0] r;
        r = w;
        case (m)
            PSPD_SWAP_BYTE:     r = {w[8:0], w[17:9], w[26:18], w[35:27]};
            PSPD_SWAP_WORD:     r = {w[17:0], w[35:18]};
            PSPD_SWAP_BYTEWORD: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
            default:            r = w;
        endcase
        return r;
    endfunction

    // Put generated bits in each byte's top position, or keep the stored ones
    function automatic logic [35:0] pspd_insert(input logic [35:0] w,
                                                input logic [3:0]  gen,
                                                input logic        en);
        logic [35:0] r;
        r = w;
        for (int n = 0; n < 4; n++)
        begin
            r[9*n+8] = en ? gen[n] : w[9*n+8];
        end
        return r;
    endfunction

endpackage

/* rtl/pspd_parity_tree.sv */
// Four 9-bit parity trees: generate from the low eight bits, check all nine
`timescale 1ns/1ps
module pspd_parity_tree
    import pspd_pkg::*;
(
    // Data and polarity
    input  wire logic [35:0] word_i,
    input  wire logic        odd_i,
    // Per-byte results
    output logic      [3:0]  gen_o,
    output logic      [3:0]  err_o
);

    // ========================================================================
    // One tree per byte
    // ========================================================================
    for (genvar n = 0; n < 4; n++)
    begin : g_tree
        // Odd: nine bits hold odd ones; even: even ones
        assign gen_o[n] = (^word_i[9*n +: 8]) ^ odd_i;
        // Ninth bit is the parity position of the
        assign err_o[n] = (^word_i[9*n +: 9]) ^ odd_i;
    end

endmodule

/* verification/pspd_port_master.sv */
// Behavioural bus master driving one FIFO port's pins
`timescale 1ns/1ps
module pspd_port_master
(
    // Clock
    input  wire logic        clk_i,
    // Port pins
    output logic      [35:0] data_o,
    output logic             select_n_o,
    output logic             enable_o,
    output logic             write_o,
    output logic             pg_o
);
    // ========================================================================
    // Idle levels at time zero
    // ========================================================================
    initial
    begin
        data_o     = 36'h0_0000_0000;
        select_n_o = 1'b1;
        enable_o   = 1'b0;
        write_o    = 1'b0;
        pg_o       = 1'b0;
    end

    // One operation cycle; back-to-back calls leave no gap
    task automatic op(input logic w, input logic g, input logic [35:0] d);
        @(posedge clk_i);
        select_n_o <= 1'b0;
        enable_o   <= 1'b1;
        write_o    <= w;
        pg_o       <= g;
        data_o     <= d;
    endtask

    // Release; inverse data so a stale value never looks valid
    task automatic idle();
        @(posedge clk_i);
        select_n_o <= 1'b1;
        enable_o   <= 1'b0;
        data_o     <= ~data_o;
    endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench of the port swap/parity datapath
`timescale 1ns/1ps
module tb_top;
    import pspd_pkg::*;
    // ========================================================================
    // Signals
    // ========================================================================
    logic        sys_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, e;
    logic        a_sel_n, a_en, a_wr, a_pg, b_sel_n, b_en, b_wr, b_pg, pe_a_n, pe_b_n;
    logic        a_we, a_rd, b_we, b_rd, sw_lo, sw_hi, sz_lo, sz_hi, end_n, a_oe, b_oe, a_ml;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [35:0] a_din, a_dout, b_din, b_dout, a_wd, b_wd, a_rdat, b_rdat, w, x;
    logic [7:0]  tbl [4] = '{8'hE4, 8'h1B, 8'h4E, 8'hB1};  // Source byte per lane
    int          miscompares, samples_checked;

    // Clock, 25 ns period
    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // ========================================================================
    // Design and port masters
    // ========================================================================
    pspd_top i_pspd_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .a_data_i(a_din),
        .a_data_o(a_dout), .a_data_oe_o(a_oe), .port_a_select_n_i(a_sel_n),
        .port_a_enable_i(a_en), .a_write_i(a_wr), .a_mail_i(a_ml), .parity_gen_port_a_i(a_pg),
        .parity_error_port_a_n_o(pe_a_n), .b_data_i(b_din), .b_data_o(b_dout),
        .b_data_oe_o(b_oe), .port_b_select_n_i(b_sel_n), .port_b_enable_i(b_en),
        .b_write_i(b_wr), .b_mail_i(1'b0), .parity_gen_port_b_i(b_pg),
        .swap_select_lo_i(sw_lo), .swap_select_hi_i(sw_hi), .size_select_lo_i(sz_lo),
        .size_select_hi_i(sz_hi), .endian_select_n_i(end_n),
        .parity_error_port_b_n_o(pe_b_n), .a_core_wdata_o(a_wd), .a_core_we_o(a_we),
        .b_core_rdata_i(b_rdat), .b_core_rd_o(b_rd), .b_core_wdata_o(b_wd),
        .b_core_we_o(b_we), .a_core_rdata_i(a_rdat), .a_core_rd_o(a_rd));
    pspd_port_master i_port_a (.clk_i(sys_clk_i), .data_o(a_din), .select_n_o(a_sel_n),
        .enable_o(a_en), .write_o(a_wr), .pg_o(a_pg));
    pspd_port_master i_port_b (.clk_i(sys_clk_i), .data_o(b_din), .select_n_o(b_sel_n),
        .enable_o(b_en), .write_o(b_wr), .pg_o(b_pg));

    // ========================================================================
    // Expectations, checks and bus cycles
    // ========================================================================
    // Parity per byte from its low eight bits
    function automatic logic [35:0] par(input logic [35:0] d, input logic odd);
        par = d;
        for (int n = 0; n < 4; n++)
            par[9*n+8] = (^d[9*n+:8]) ^ odd;
    endfunction

    // Whole-byte moves, taken from the lane table
    function automatic logic [35:0] xswap(input logic [35:0] d, input int c);
        for (int k = 0; k < 4; k++)
            xswap[9*k+:9] = d[9*tbl[c][2*k+:2]+:9];
    endfunction

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk_i);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20)
        begin
            miscompares++;
            summarize();
        end
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Outputs land on the third edge after the pins
    task automatic settle();
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial
    begin
        {psel, penable, pwrite, sw_lo, sw_hi, sz_lo, sz_hi, end_n, nrst_i, a_ml} = 10'h000;
        paddr  = 8'h00;
        pwdata = 32'h0000_0000;
        a_rdat = 36'h0_3C5A_9617;
        b_rdat = 36'h9_8765_4321;
        miscompares = 0;
        samples_checked = 0;
        repeat (4) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        apb(1'b0, PSPD_OFF_CTRL, 32'h0000_0000);
        chk(36'(rd), 36'h0_0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(36'(e), 36'h0_0000_0001);
        w = par(36'h0_3C5A_9617, 1'b0);
        for (int bad = 0; bad < 2; bad++)
        begin
            i_port_a.op(1'b1, 1'b1, w ^ {bad[0], 32'h0000_0000});
            i_port_a.idle();
            settle();
            chk(a_wd, w ^ {bad[0], 32'h0000_0000});
            chk({a_we, pe_a_n}, 36'(2'b11 ^ bad));
        end
        apb(1'b0, PSPD_OFF_STATUS, 32'h0000_0000);
        chk(36'(rd[0]), 36'h0_0000_0001);
        apb(1'b1, PSPD_OFF_CTRL, 32'h0000_0001);
        for (int g = 0; g < 2; g++)
        begin
            i_port_a.op(1'b0, g[0], 36'h0_0000_0000);
            i_port_a.idle();
            settle();
            chk(a_dout, g ? par(a_rdat, 1'b1) : a_rdat);
            chk({a_oe, a_rd}, 36'h0_0000_0003);
        end
        // Mailbox write then generating mailbox read; no core traffic
        a_ml <= 1'b1;
        i_port_a.op(1'b1, 1'b0, w);
        i_port_a.op(1'b0, 1'b1, 36'h0_0000_0000);
        i_port_a.idle();
        settle();
        chk(a_dout, par(36'h0_0000_0000, 1'b1));
        for (int c = 0; c < 4; c++)
        begin
            {sw_lo, sw_hi} <= 2'(c);
            w = xswap(b_rdat, c);
            i_port_b.op(1'b0, c != 1, 36'h0_0000_0000);
            i_port_b.idle();
            settle();
            chk(b_dout, (c == 1) ? w : par(w, 1'b1));
            chk({b_oe, b_rd}, 36'h0_0000_0003);
        end
        {sw_lo, sw_hi, sz_lo, end_n} <= 4'b0110;
        w = par(36'h0_1122_3344, 1'b1);
        x = xswap(b_rdat, 1);
        // Byte-wide big endian: four reads, then four writes, top byte first
        fork
            begin
                for (int i = 0; i < 8; i++)
                    i_port_b.op(i > 3, 1'b0, {w[9*((7-i)%4)+:9], 27'h000_0000});
                i_port_b.idle();
            end
            begin
                repeat (4) @(posedge sys_clk_i);
                for (int i = 0; i < 8; i++)
                begin
                    #1;
                    if (i < 4)
                        chk({b_dout[35:27], b_rd}, {x[27-9*i+:9], i == 3});
                    else
                        chk({pe_b_n, b_we, b_oe}, {1'b1, i == 7, 1'b0});
                    if (i == 7)
                        chk(b_wd, xswap(w, 1));
                    @(posedge sys_clk_i);
                end
            end
        join
        summarize();
    end
endmodule
